// >>> logic/dic_pkg.sv
package dic_pkg;
  // two-wire select code and byte framing
  localparam logic [6:0] DEV_ADDR = 7'h43;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] NO_REG = 4'hF;

  // device sub-addresses
  localparam logic [7:0] A_VERSION = 8'h00;
  localparam logic [7:0] A_IDENT = 8'h01;
  localparam logic [7:0] A_SYNTH_CTL = 8'h05;
  localparam logic [7:0] A_SYNTH_MUL = 8'h06;
  localparam logic [7:0] A_SYNTH_DIV = 8'h07;
  localparam logic [7:0] A_REQUEST_LINE_POLARITY = 8'h0C;
  localparam logic [7:0] A_CLK_POL = 8'h0D;
  localparam logic [7:0] A_ERROR = 8'h0F;
  localparam logic [7:0] A_SOFT_RST = 8'h10;
  localparam logic [7:0] A_PLAYBACK_ENABLE = 8'h13;
  localparam logic [7:0] A_MUTE = 8'h14;
  localparam logic [7:0] A_BREAK = 8'h16;
  localparam logic [7:0] A_REQ_EN = 8'h18;
  localparam logic [7:0] A_SYNC = 8'h40;
  localparam logic [7:0] A_ANC_L = 8'h41;
  localparam logic [7:0] A_ANC_H = 8'h42;
  localparam logic [7:0] A_RUN = 8'h72;

  // writable registers: address and reset value by index
  localparam int NRW = 10;
  localparam logic [7:0] RW_ADDR [NRW] = '{A_SYNTH_CTL, A_SYNTH_MUL, A_SYNTH_DIV, A_REQUEST_LINE_POLARITY,
    A_CLK_POL, A_PLAYBACK_ENABLE, A_MUTE, A_BREAK, A_REQ_EN, A_RUN};
  localparam logic [7:0] RW_RST [NRW] = '{8'hA1, 8'h0C, 8'h00, 8'h01, 8'h04, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00};
  localparam int I_REQUEST_LINE_POLARITY = 3;
  localparam int I_PLAYBACK_ENABLE = 5;
  localparam int I_MUTE = 6;
  localparam int I_REQ_EN = 8;
  localparam int I_RUN = 9;
  localparam int REQUEST_LINE_POLARITY_INV = 2;

  // controller apb map and command bits
  localparam logic [11:0] H_CMD = 12'h000;
  localparam logic [11:0] H_TX = 12'h004;
  localparam logic [11:0] H_RX = 12'h008;
  localparam logic [11:0] H_STAT = 12'h00C;
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_NACK = 4;
  localparam int QTR_MIN = 4;

  typedef enum logic [2:0] {
    D_IDLE = 3'b001, D_INIT = 3'b010, D_DECODE = 3'b100
  } dic_dec_state_type;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_RX = 5'b00010, S_RXACK = 5'b00100, S_TX = 5'b01000, S_TXACK = 5'b10000
  } dic_slave_state_type;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_START = 4'b0010, H_BIT = 4'b0100, H_STOP = 4'b1000
  } dic_host_state_type;
endpackage

// >>> logic/dic_link_if.sv
`timescale 1ns/1ps
interface dic_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open-drain line with pull-up: low whenever any party drives a low
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface

// >>> logic/dic_sync.sv
`timescale 1ns/1ps
module dic_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // async in, synced out
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("dic_sync width must be at least one");
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule // dic_sync

// >>> logic/dic_device.sv
`timescale 1ns/1ps
module dic_device #(
  // identity values below are arbitrary
  parameter logic [7:0] VERSION_CODE = 8'h10,
  parameter logic [7:0] IDENT_CODE = 8'h5A
) (
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // two-wire link
  dic_link_if.dev link,
  // bitstream flow
  input wire logic pull_mode_select_pin_in,
  input wire logic buf_space_in,
  output logic data_req_out,
  output logic frac_adjust_en_out,
  // decoder core
  input wire logic first_samples_in,
  input wire logic [7:0] sync_status_in,
  input wire logic [15:0] anc_count_in,
  input wire logic [7:0] error_code_in,
  output logic clk_run_out,
  output logic decode_en_out,
  output logic pcm_pass_out
);
  dic_pkg::dic_slave_state_type st_q;
  dic_pkg::dic_dec_state_type dec_q;
  logic scl_s;
  logic sda_s;
  logic pull_s;
  logic scl_p_q;
  logic sda_p_q;
  logic start_det;
  logic stop_det;
  logic rise;
  logic fall;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic first_q;
  logic ptr_ok_q;
  logic rw_q;
  logic ack_q;
  logic oe_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_byte;
  logic [3:0] rd_idx;
  logic [3:0] wr_idx;
  logic wr_stb;
  logic soft_q;
  logic [7:0] regs_q [dic_pkg::NRW];
  logic eff_playback_enable_q;
  logic eff_mute_q;
  logic run;

  function automatic logic [3:0] rw_index(input logic [7:0] a);
    rw_index = dic_pkg::NO_REG;
    for (int i = 0; i < dic_pkg::NRW; i++) begin
      if (a == dic_pkg::RW_ADDR[i]) begin
        rw_index = 4'(i);
      end
    end
  endfunction

  // strap and link pins are asynchronous to clk_in
  dic_sync #(.W(3), .RST_VAL(3'h6)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({link.scl, link.sda, pull_mode_select_pin_in}),
    .q_out({scl_s, sda_s, pull_s})
  );

  // only ever pulls data low; the serial clock is an input here
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rise = scl_s & ~scl_p_q;
  assign fall = ~scl_s & scl_p_q;
  assign wr_stb = (st_q == dic_pkg::S_RX) & fall & (cnt_q == dic_pkg::BYTE_BITS) & ~first_q
    & ptr_ok_q;
  assign wr_idx = rw_index(ptr_q);

  always_comb begin
    rd_idx = rw_index(ptr_q);
    case (ptr_q)
      dic_pkg::A_VERSION: rd_byte = VERSION_CODE;
      dic_pkg::A_IDENT: rd_byte = IDENT_CODE;
      dic_pkg::A_ERROR: rd_byte = error_code_in;
      dic_pkg::A_SYNC: rd_byte = sync_status_in;
      dic_pkg::A_ANC_L: rd_byte = anc_count_in[7:0];
      dic_pkg::A_ANC_H: rd_byte = anc_count_in[15:8];
      default: rd_byte = (rd_idx == dic_pkg::NO_REG) ? 8'h00 : regs_q[rd_idx];
    endcase
  end

  // byte engine of the slave
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= dic_pkg::S_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      first_q <= 1'b0;
      ptr_ok_q <= 1'b0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      ptr_q <= 8'h00;
    end else if (stop_det) begin
      st_q <= dic_pkg::S_IDLE;
      oe_q <= 1'b0;
    end else if (start_det) begin
      st_q <= dic_pkg::S_RX;
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      ptr_ok_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      case (st_q)
        dic_pkg::S_RX: begin
          if (rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (fall && cnt_q == dic_pkg::BYTE_BITS) begin
            cnt_q <= 4'h0;
            if (first_q) begin
              if (sh_q[7:1] == dic_pkg::DEV_ADDR) begin
                st_q <= dic_pkg::S_RXACK;
                oe_q <= 1'b1;
                rw_q <= sh_q[0];
                first_q <= 1'b0;
              end else begin
                st_q <= dic_pkg::S_IDLE;
              end
            end else begin
              st_q <= dic_pkg::S_RXACK;
              oe_q <= 1'b1;
              if (!ptr_ok_q) begin
                ptr_q <= sh_q;
                ptr_ok_q <= 1'b1;
              end else begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
        end
        dic_pkg::S_RXACK: begin
          if (fall) begin
            if (rw_q) begin
              st_q <= dic_pkg::S_TX;
              sh_q <= rd_byte;
              oe_q <= ~rd_byte[7];
              ptr_q <= ptr_q + 8'h01;
            end else begin
              st_q <= dic_pkg::S_RX;
              oe_q <= 1'b0;
            end
          end
        end
        dic_pkg::S_TX: begin
          if (rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (fall) begin
            if (cnt_q == dic_pkg::BYTE_BITS) begin
              st_q <= dic_pkg::S_TXACK;
              oe_q <= 1'b0;
              cnt_q <= 4'h0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
        end
        dic_pkg::S_TXACK: begin
          if (rise) begin
            ack_q <= ~sda_s;
          end else if (fall) begin
            if (ack_q) begin
              st_q <= dic_pkg::S_TX;
              sh_q <= rd_byte;
              oe_q <= ~rd_byte[7];
              ptr_q <= ptr_q + 8'h01;
            end else begin
              st_q <= dic_pkg::S_IDLE;
            end
          end
        end
        default: st_q <= dic_pkg::S_IDLE;
      endcase
    end
  end

  // writing the soft reset address restores the defaults one cycle later
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_stb & (ptr_q == dic_pkg::A_SOFT_RST);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < dic_pkg::NRW; i++) begin
        regs_q[i] <= dic_pkg::RW_RST[i];
      end
    end else if (soft_q) begin
      for (int i = 0; i < dic_pkg::NRW; i++) begin
        regs_q[i] <= dic_pkg::RW_RST[i];
      end
    end else if (wr_stb && wr_idx != dic_pkg::NO_REG) begin
      regs_q[wr_idx] <= sh_q;
    end
  end

  assign run = regs_q[dic_pkg::I_RUN][0];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dec_q <= dic_pkg::D_IDLE;
    end else begin
      case (dec_q)
        dic_pkg::D_IDLE: if (run) dec_q <= dic_pkg::D_INIT;
        dic_pkg::D_INIT: begin
          if (!run) begin
            dec_q <= dic_pkg::D_IDLE;
          end else if (first_samples_in) begin
            dec_q <= dic_pkg::D_DECODE;
          end
        end
        dic_pkg::D_DECODE: if (!run) dec_q <= dic_pkg::D_IDLE;
        default: dec_q <= dic_pkg::D_IDLE;
      endcase
    end
  end

  // playback_enable and mute are frozen during init, picked up on the step to decode
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      eff_playback_enable_q <= dic_pkg::RW_RST[dic_pkg::I_PLAYBACK_ENABLE][0];
      eff_mute_q <= dic_pkg::RW_RST[dic_pkg::I_MUTE][0];
    end else if (dec_q != dic_pkg::D_INIT || first_samples_in) begin
      eff_playback_enable_q <= regs_q[dic_pkg::I_PLAYBACK_ENABLE][0];
      eff_mute_q <= regs_q[dic_pkg::I_MUTE][0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_run_out <= 1'b0;
      decode_en_out <= 1'b0;
      pcm_pass_out <= 1'b0;
    end else begin
      case (dec_q)
        dic_pkg::D_IDLE: begin
          clk_run_out <= regs_q[dic_pkg::I_MUTE][0];
          decode_en_out <= 1'b0;
          pcm_pass_out <= 1'b0;
        end
        dic_pkg::D_INIT: begin
          decode_en_out <= 1'b1;
          pcm_pass_out <= 1'b0;
        end
        default: begin
          clk_run_out <= eff_playback_enable_q | eff_mute_q;
          decode_en_out <= eff_playback_enable_q;
          pcm_pass_out <= eff_playback_enable_q & ~eff_mute_q;
        end
      endcase
    end
  end

  // strap high selects pull mode; in broadcast the line rests inactive
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_req_out <= 1'b0;
      frac_adjust_en_out <= 1'b0;
    end else begin
      data_req_out <= (pull_s & regs_q[dic_pkg::I_REQ_EN][0] & buf_space_in)
        ^ regs_q[dic_pkg::I_REQUEST_LINE_POLARITY][dic_pkg::REQUEST_LINE_POLARITY_INV];
      frac_adjust_en_out <= ~pull_s;
    end
  end
endmodule // dic_device

// >>> logic/dic_host.sv
`timescale 1ns/1ps
module dic_host #(
  parameter int QTR_CYCLES = 4
) (
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // two-wire link
  dic_link_if.host link
);
  localparam int QW = (QTR_CYCLES > 1) ? $clog2(QTR_CYCLES) : 1;

  // the device needs a few of its own cycles per quarter to resample the line
  if (QTR_CYCLES < dic_pkg::QTR_MIN) begin : g_chk
    $error("QTR_CYCLES too small for the device sampler");
  end

  dic_pkg::dic_host_state_type st_q;
  logic [QW-1:0] qc_q;
  logic [1:0] ph_q;
  logic scl_q;
  logic oe_q;
  logic nack_q;
  logic [4:0] cmd_q;
  logic [4:0] cmd_left;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [3:0] bc_q;
  logic sda_s;
  logic tick;
  logic access;
  logic cmd_wr;
  logic rd_op;

  function automatic dic_pkg::dic_host_state_type step_of(input logic [4:0] c);
    if (c[dic_pkg::CMD_START]) begin
      step_of = dic_pkg::H_START;
    end else if (c[dic_pkg::CMD_WRITE] | c[dic_pkg::CMD_READ]) begin
      step_of = dic_pkg::H_BIT;
    end else if (c[dic_pkg::CMD_STOP]) begin
      step_of = dic_pkg::H_STOP;
    end else begin
      step_of = dic_pkg::H_IDLE;
    end
  endfunction

  // data level to present while scl is low at the entry of a step
  function automatic logic entry_oe(input logic [4:0] c, input logic [7:0] tx);
    entry_oe = (step_of(c) == dic_pkg::H_STOP)
      | ((step_of(c) == dic_pkg::H_BIT) & c[dic_pkg::CMD_WRITE] & ~tx[7]);
  endfunction

  dic_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(link.sda),
    .q_out(sda_s)
  );

  assign link.scl = scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_q;
  assign access = psel_in & penable_in & pready_out;
  // a command written while busy is dropped
  assign cmd_wr = access & pwrite_in & (paddr_in == dic_pkg::H_CMD) & (st_q == dic_pkg::H_IDLE);
  assign tick = qc_q == QW'(QTR_CYCLES - 1);
  assign rd_op = ~cmd_q[dic_pkg::CMD_WRITE];

  always_comb begin
    cmd_left = cmd_q;
    case (st_q)
      dic_pkg::H_START: cmd_left[dic_pkg::CMD_START] = 1'b0;
      dic_pkg::H_BIT: begin
        if (cmd_q[dic_pkg::CMD_WRITE]) begin
          cmd_left[dic_pkg::CMD_WRITE] = 1'b0;
        end else begin
          cmd_left[dic_pkg::CMD_READ] = 1'b0;
        end
      end
      dic_pkg::H_STOP: cmd_left[dic_pkg::CMD_STOP] = 1'b0;
      default: cmd_left = cmd_q;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      qc_q <= '0;
    end else if (st_q == dic_pkg::H_IDLE || tick) begin
      qc_q <= '0;
    end else begin
      qc_q <= qc_q + 1'b1;
    end
  end

  // each step is four quarters: scl rises after q0, data sampled after q1
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= dic_pkg::H_IDLE;
      ph_q <= 2'h0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      nack_q <= 1'b0;
      cmd_q <= 5'h00;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      bc_q <= 4'h0;
    end else if (st_q == dic_pkg::H_IDLE) begin
      ph_q <= 2'h0;
      bc_q <= 4'h0;
      if (cmd_wr) begin
        cmd_q <= pwdata_in[4:0];
        st_q <= step_of(pwdata_in[4:0]);
        oe_q <= entry_oe(pwdata_in[4:0], tx_q);
        sh_q <= tx_q;
        nack_q <= 1'b0;
      end
    end else if (tick) begin
      ph_q <= ph_q + 2'h1;
      case (ph_q)
        2'h0: scl_q <= 1'b1;
        2'h1: begin
          if (st_q == dic_pkg::H_START) oe_q <= 1'b1;
          if (st_q == dic_pkg::H_STOP) oe_q <= 1'b0;
          if (st_q == dic_pkg::H_BIT) begin
            if (bc_q == dic_pkg::BYTE_BITS) begin
              if (!rd_op) nack_q <= sda_s;
            end else if (rd_op) begin
              sh_q <= {sh_q[6:0], sda_s};
            end
          end
        end
        2'h2: if (st_q != dic_pkg::H_STOP) scl_q <= 1'b0;
        default: begin
          if (st_q == dic_pkg::H_BIT && bc_q != dic_pkg::BYTE_BITS) begin
            bc_q <= bc_q + 4'h1;
            if (rd_op) begin
              oe_q <= (bc_q == dic_pkg::BYTE_BITS - 4'h1) & ~cmd_q[dic_pkg::CMD_NACK];
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= (bc_q != dic_pkg::BYTE_BITS - 4'h1) & ~sh_q[6];
            end
          end else begin
            if (st_q == dic_pkg::H_BIT && rd_op) rx_q <= sh_q;
            cmd_q <= cmd_left;
            st_q <= step_of(cmd_left);
            oe_q <= entry_oe(cmd_left, tx_q);
            sh_q <= tx_q;
            bc_q <= 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_q <= 8'h00;
    end else if (access && pwrite_in && paddr_in == dic_pkg::H_TX) begin
      tx_q <= pwdata_in[7:0];
    end
  end

  // zero-wait slave: ready and read data come in the first access cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      if (psel_in && !penable_in) begin
        pslverr_out <= 1'b0;
        case (paddr_in)
          dic_pkg::H_CMD: prdata_out <= {27'h0, cmd_q};
          dic_pkg::H_TX: prdata_out <= {24'h0, tx_q};
          dic_pkg::H_RX: prdata_out <= {24'h0, rx_q};
          dic_pkg::H_STAT: prdata_out <= {30'h0, nack_q, st_q != dic_pkg::H_IDLE};
          default: begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // dic_host

// >>> verif/dic_link_assertions.sv
`timescale 1ns/1ps
module dic_link_assertions (
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // link
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic scl_q, sda_q, act_q, match_q, rw_q, rise, start, stop;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (rise) sh_q <= {sh_q[6:0], sda};
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) act_q <= 1'h0;
    else if (start) act_q <= 1'h1;
    else if (stop) act_q <= 1'h0;
  end
  // counts only what the wire shows, so a slip in either end is seen
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      match_q <= 1'h0;
      rw_q <= 1'h0;
    end else if (start) begin
      bit_q <= 4'h0;
      byte_q <= 2'h0;
    end else if (rise) begin
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == 4'h8 && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
      if (bit_q == 4'h8 && byte_q == 2'h0) begin
        match_q <= (sh_q[7:1] == dic_pkg::DEV_ADDR);
        rw_q <= sh_q[0];
      end
    end
  end
  ack_addr_a: assert property (rise && bit_q == 4'h8 && byte_q == 2'h0 &&
    sh_q[7:1] == dic_pkg::DEV_ADDR |-> !sda) else $error("address not acknowledged");
  no_ack_other_a: assert property (rise && bit_q == 4'h8 && byte_q == 2'h0 &&
    sh_q[7:1] != dic_pkg::DEV_ADDR |-> !dev_sda_oe) else $error("foreign address acknowledged");
  ack_write_a: assert property (rise && bit_q == 4'h8 && byte_q != 2'h0 &&
    match_q && !rw_q |-> !sda) else $error("written byte not acknowledged");
  rel_read_a: assert property (rise && bit_q == 4'h8 && byte_q != 2'h0 &&
    match_q && rw_q |-> !dev_sda_oe) else $error("device held ack slot of read byte");
  quiet_write_a: assert property (rise && bit_q != 4'h8 &&
    (byte_q == 2'h0 || !rw_q) |-> !dev_sda_oe) else $error("device drove data slot");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device moved data while clock high");
  idle_quiet_a: assert property (!act_q |-> !dev_sda_oe)
    else $error("device drove idle bus");
  scl_high_a: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  cover property (rise && bit_q == 4'h8 && byte_q != 2'h0 && match_q && rw_q);
  cover property (start && act_q);
  cover property (stop);
  cover property (rise && bit_q == 4'h8 && byte_q == 2'h0 && sh_q[7:1] != dic_pkg::DEV_ADDR);
endmodule // dic_link_assertions

// >>> verif/test_decoder_i2c_control_port.sv
`timescale 1ns/1ps
module test_decoder_i2c_control_port;
  // identity values are arbitrary
  localparam logic [7:0] VER = 8'h21;
  localparam logic [7:0] IDC = 8'h3C;
  logic clk_in = 1'h0, rst_in = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pull = 1'h1, space = 1'h0, first = 1'h0;
  logic data_req, frac, clk_run, dec_en, pcm;
  logic [7:0] exp_q[$];
  int fails = 0, compares = 0;
  dic_link_if link_bus();
  dic_host dic_host_inst (.clk_in(clk_in), .rst_in(rst_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link_bus));
  dic_device #(.VERSION_CODE(VER), .IDENT_CODE(IDC)) dic_device_inst (.clk_in(clk_in),
    .rst_in(rst_in), .link(link_bus), .pull_mode_select_pin_in(pull), .buf_space_in(space),
    .data_req_out(data_req), .frac_adjust_en_out(frac), .first_samples_in(first),
    .sync_status_in(8'h5C), .anc_count_in(16'h1234), .error_code_in(8'h02),
    .clk_run_out(clk_run), .decode_en_out(dec_en), .pcm_pass_out(pcm));
  dic_link_assertions dic_link_assertions_inst (.clk_in(clk_in), .rst_in(rst_in),
    .scl(link_bus.scl), .host_sda_o(link_bus.host_sda_o), .host_sda_oe(link_bus.host_sda_oe),
    .dev_sda_o(link_bus.dev_sda_o), .dev_sda_oe(link_bus.dev_sda_oe), .sda(link_bus.sda));
  initial forever #20 clk_in = ~clk_in;
  task finish_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'h1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask
  // one controller command, then poll until the byte has left the wire
  task link(input logic [7:0] cmd, input logic [7:0] tx, input logic nk);
    int n;
    n = 0;
    apb(1'h1, dic_pkg::H_TX, {24'h0, tx});
    apb(1'h1, dic_pkg::H_CMD, {24'h0, cmd});
    do begin
      apb(1'h0, dic_pkg::H_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 500);
    chk("link_idle", 32'h0, {31'h0, rd[0]});
    if (cmd[1]) chk("byte_ack", {31'h0, nk}, {31'h0, rd[1]});
  endtask
  task dev_wr(input logic [7:0] sub, input logic [15:0] v, input logic two);
    link(8'h03, 8'h86, 1'h0);
    link(8'h02, sub, 1'h0);
    if (two) link(8'h02, v[15:8], 1'h0);
    link(8'h0A, v[7:0], 1'h0);
  endtask
  task dev_rd(input logic [7:0] sub);
    int n;
    n = exp_q.size();
    link(8'h03, 8'h86, 1'h0);
    link(8'h0A, sub, 1'h0);
    link(8'h03, 8'h87, 1'h0);
    for (int i = 0; i < n; i++) begin
      link((i == n - 1) ? 8'h1C : 8'h04, 8'h00, 1'h0);
      apb(1'h0, dic_pkg::H_RX, 32'h0);
      chk("dev_byte", {24'h0, exp_q.pop_front()}, {24'h0, rd[7:0]});
    end
  endtask
  task s_table;
    exp_q = '{VER, IDC, 8'h00, 8'h00, 8'h00, 8'hA1, 8'h0C, 8'h00};
    dev_rd(8'h00);
    exp_q = '{8'h00, 8'h01, 8'h04, 8'h00, 8'h02, 8'h00};
    dev_rd(8'h0B);
    exp_q = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    dev_rd(8'h13);
    exp_q = '{8'h5C, 8'h34, 8'h12};
    dev_rd(8'h40);
  endtask
  task s_write;
    dev_wr(8'h0C, 16'h0500, 1'h1);
    dev_wr(8'h40, 16'h00FF, 1'h0);
    exp_q = '{8'h05, 8'h00};
    dev_rd(8'h0C);
    exp_q = '{8'h5C};
    dev_rd(8'h40);
    link(8'h0B, 8'h90, 1'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
  endtask
  task s_flow;
    dev_wr(8'h18, 16'h0001, 1'h0);
    space <= 1'h1;
    repeat (4) @(posedge clk_in);
    chk("req_inv", 32'h0, {31'h0, data_req});
    space <= 1'h0;
    repeat (4) @(posedge clk_in);
    chk("halt_inv", 32'h1, {31'h0, data_req});
    dev_wr(8'h0C, 16'h0001, 1'h0);
    chk("halt", 32'h0, {31'h0, data_req});
    chk("frac_pull", 32'h0, {31'h0, frac});
    space <= 1'h1;
    repeat (4) @(posedge clk_in);
    chk("req", 32'h1, {31'h0, data_req});
    pull <= 1'h0;
    repeat (6) @(posedge clk_in);
    chk("req_bcast", 32'h0, {31'h0, data_req});
    chk("frac_bcast", 32'h1, {31'h0, frac});
    pull <= 1'h1;
  endtask
  task s_state;
    logic [1:0] pm;
    chk("idle", 32'h0, {29'h0, clk_run, dec_en, pcm});
    dev_wr(8'h14, 16'h0001, 1'h0);
    chk("idle_mute", 32'h4, {29'h0, clk_run, dec_en, pcm});
    dev_wr(8'h72, 16'h0001, 1'h0);
    dev_wr(8'h13, 16'h0000, 1'h1);
    chk("init", 32'h6, {29'h0, clk_run, dec_en, pcm});
    first <= 1'h1;
    @(posedge clk_in);
    first <= 1'h0;
    repeat (3) @(posedge clk_in);
    chk("decode", 32'h0, {29'h0, clk_run, dec_en, pcm});
    for (int i = 0; i < 4; i++) begin
      pm = i[1:0];
      dev_wr(8'h13, {7'h0, pm[1], 7'h0, pm[0]}, 1'h1);
      chk("table", {29'h0, pm[1] | pm[0], pm[1], pm[1] & ~pm[0]},
        {29'h0, clk_run, dec_en, pcm});
    end
    dev_wr(8'h72, 16'h0000, 1'h0);
    chk("back_idle", 32'h0, {31'h0, dec_en});
    // soft reset must undo the earlier clock polarity and mute writes
    dev_wr(8'h10, 16'h0001, 1'h0);
    exp_q = '{8'h04, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    dev_rd(8'h0D);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (6) @(posedge clk_in);
    s_table();
    s_write();
    s_flow();
    s_state();
    finish_test();
  end
  // a run of roughly 16k cycles is expected; five times that means a hang
  initial begin
    #3200000;
    fails++;
    finish_test();
  end
endmodule // test_decoder_i2c_control_port
